// >>> design/pgr_ctrl.v
`timescale 1ns/1ps
`include "pgr_map.vh"
// Contract
// [RQ1] A peripheral reads not ready while its run clock is off or its reset is held; the code clears ready one cycle after the run enable clears.
// [RQ2] Ready stays false through the settling interval after enable or reset release.
// [RQ3] Each peripheral has a readable ready bit, true only when accessible.
// [RQ4] A soft reset request pulses that peripheral's reset for a short time, then releases it.
// [RQ5] A soft reset resets only the targeted peripheral and no other.
// [RQ6] With its sleep enable clear, a peripheral's clock stops while the processor sleeps.
// [RQ7] A run-enabled peripheral gets its clock back on wake and keeps its state.
// [RQ8] Sleep settings act only while global sleep gating is on; otherwise kept but ignored.
// [RQ9] A peripheral counts as enabled five cycles after the enabling write; earlier access faults; the code sets ready six cycles after the write.
// [RQ10] Run enables clear at power-up; a disabled peripheral neither runs nor answers.
// [RQ11] With its sleep enable set, a peripheral stays clocked during sleep.
// [RQ12] Run, sleep, reset request and ready bits exist per peripheral at one common index.
module pgr_ctrl #(
  parameter NPERIPH = 32
) (
  input wire mclk,
  input wire reset_n,
  input wire ce,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdata,
  input wire cpuSleeping,
  input wire [NPERIPH-1:0] periphAccess,
  output reg [NPERIPH-1:0] busFault,
  output wire [NPERIPH-1:0] periphClkEn,
  output wire [NPERIPH-1:0] periphResetN,
  output wire [NPERIPH-1:0] periphReady
);
  // full-word reset values, sliced to the peripheral count below
  localparam [31:0] RUN_RST = `PGR_RUN_RST;
  localparam [31:0] SLEEP_RST = `PGR_SLEEP_RST;
  reg rstMeta_q;
  reg rstSync_q;
  reg [NPERIPH-1:0] runEn_q;
  reg [NPERIPH-1:0] sleepEn_q;
  reg [NPERIPH-1:0] softReset_q;
  reg gateEn_q;
  reg [31:0] rdData_d;

  // pad a peripheral vector to a bus word
  function [31:0] toWord;
    input [NPERIPH-1:0] v;
    begin
      toWord = 32'h00000000;
      toWord[NPERIPH-1:0] = v;
    end
  endfunction

  // reset release through two flops, assertion stays asynchronous
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // control registers; soft reset request is a one-cycle pulse
  always @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      runEn_q <= RUN_RST[NPERIPH-1:0]; // [RQ10]
      sleepEn_q <= SLEEP_RST[NPERIPH-1:0];
      gateEn_q <= `PGR_GATE_RST;
      softReset_q <= {NPERIPH{1'b0}};
    end else if (ce) begin
      softReset_q <= {NPERIPH{1'b0}};
      if (regWr) begin
        case (regAddr)
          `PGR_RUN_OFS: runEn_q <= regWdata[NPERIPH-1:0];
          `PGR_SLEEP_OFS: sleepEn_q <= regWdata[NPERIPH-1:0]; // [RQ8]
          `PGR_SRST_OFS: softReset_q <= regWdata[NPERIPH-1:0]; // [RQ5]
          `PGR_GATE_OFS: gateEn_q <= regWdata[`PGR_GATE_BIT];
          default: ;
        endcase
      end
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    case (regAddr)
      `PGR_RUN_OFS: rdData_d = toWord(runEn_q);
      `PGR_SLEEP_OFS: rdData_d = toWord(sleepEn_q);
      `PGR_SRST_OFS: rdData_d = 32'h00000000;
      `PGR_READY_OFS: rdData_d = toWord(periphReady); // [RQ3]
      `PGR_GATE_OFS: rdData_d = {31'h00000000, gateEn_q};
      default: rdData_d = 32'h00000000;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      regRdata <= 32'h00000000;
    end else if (ce) begin
      regRdata <= regRd ? rdData_d : 32'h00000000;
    end
  end

  // accesses to a peripheral that is not ready fault, one cycle later
  always @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      busFault <= {NPERIPH{1'b0}};
    end else if (ce) begin
      busFault <= periphAccess & ~periphReady; // [RQ9] [RQ10]
    end
  end

  // same index for every per-peripheral bit
  genvar i;
  generate
    for (i = 0; i < NPERIPH; i = i + 1) begin : gSlot
      pgr_slot uSlot (
        .mclk(mclk),
        .rstSyncN(rstSync_q),
        .ce(ce),
        .runEn(runEn_q[i]), // [RQ12]
        .sleepEn(sleepEn_q[i]),
        .gateEn(gateEn_q),
        .sleeping(cpuSleeping),
        .softReset(softReset_q[i]),
        .periphResetN(periphResetN[i]),
        .periphReady(periphReady[i]),
        .periphClkEn(periphClkEn[i])
      );
    end
  endgenerate
endmodule

// >>> design/pgr_map.vh
`ifndef PGR_MAP_VH
`define PGR_MAP_VH
// register offsets (byte addresses, one aligned word each)
`define PGR_RUN_OFS 8'h00
`define PGR_SLEEP_OFS 8'h04
`define PGR_SRST_OFS 8'h08
`define PGR_READY_OFS 8'h0C
`define PGR_GATE_OFS 8'h10
// field positions
`define PGR_GATE_BIT 0
// reset values
`define PGR_RUN_RST 32'h00000000
`define PGR_SLEEP_RST 32'h00000000
`define PGR_GATE_RST 1'b0
// timing counts in clock cycles
`define PGR_ENABLE_CYCLES 5
`define PGR_SRST_CYCLES 4
`define PGR_CNT_W 3
`endif

// >>> design/pgr_slot.v
`timescale 1ns/1ps
`include "pgr_map.vh"
// one peripheral: reset pulse, settle counter, ready and clock gate
module pgr_slot (
  input wire mclk,
  input wire rstSyncN,
  input wire ce,
  input wire runEn,
  input wire sleepEn,
  input wire gateEn,
  input wire sleeping,
  input wire softReset,
  output reg periphResetN,
  output reg periphReady,
  output wire periphClkEn
);
  // counts sized to the counter so loads never truncate silently
  localparam [`PGR_CNT_W-1:0] SRST_LEN = `PGR_SRST_CYCLES;
  localparam [`PGR_CNT_W-1:0] SETTLE_LEN = `PGR_ENABLE_CYCLES - 1;
  reg [`PGR_CNT_W-1:0] rstCnt_q;
  reg [`PGR_CNT_W-1:0] settleCnt_q;
  reg runPrev_q;
  wire inReset;
  wire settled;

  assign inReset = (rstCnt_q != {`PGR_CNT_W{1'b0}});
  assign settled = (settleCnt_q == {`PGR_CNT_W{1'b0}});

  // reset pulse and settle interval counters
  always @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rstCnt_q <= {`PGR_CNT_W{1'b0}};
      settleCnt_q <= {`PGR_CNT_W{1'b0}};
      runPrev_q <= 1'b0;
      periphResetN <= 1'b1;
      periphReady <= 1'b0;
    end else if (ce) begin
      runPrev_q <= runEn;
      if (softReset) begin
        rstCnt_q <= SRST_LEN; // [RQ4]
      end else if (inReset) begin
        rstCnt_q <= rstCnt_q - 1'b1; // [RQ4]
      end
      // restart settling on enable edge or reset release
      if (softReset || inReset || (runEn && !runPrev_q)) begin
        settleCnt_q <= SETTLE_LEN; // [RQ2] [RQ9]
      end else if (!settled) begin
        settleCnt_q <= settleCnt_q - 1'b1; // [RQ9]
      end
      periphResetN <= !(softReset || (rstCnt_q > 1)); // [RQ5]
      // not ready when disabled, in reset, or settling
      periphReady <= runEn && !softReset && !inReset && settled
        && runPrev_q; // [RQ1] [RQ2] [RQ3]
    end
  end

  // run gating; sleep gating only when global gating is enabled
  assign periphClkEn = runEn && !(sleeping && gateEn && !sleepEn); // [RQ6] [RQ7] [RQ8] [RQ11]
endmodule

// >>> verification/periph_gate_reset_ready_tb.sv
`timescale 1ns/1ps
module periph_gate_reset_ready_tb;
  reg mclk = 1'b0;
  reg reset_n = 1'b0;
  reg ce = 1'b1;
  reg [7:0] regAddr = 8'h00;
  reg [31:0] regWdata = 32'h0;
  reg regWr = 1'b0;
  reg regRd = 1'b0;
  reg cpuSleeping = 1'b0;
  reg [3:0] periphAccess = 4'h0;
  wire [31:0] regRdata;
  wire [3:0] busFault, periphClkEn, periphResetN, periphReady;
  wire [7:0] st0, st1;
  integer failures = 0;
  integer cmp_count = 0;
  reg [7:0] held;
  always #4 mclk = ~mclk;
  pgr_ctrl #(.NPERIPH(4)) DUT (.mclk(mclk), .reset_n(reset_n), .ce(ce),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .cpuSleeping(cpuSleeping), .periphAccess(periphAccess),
    .busFault(busFault), .periphClkEn(periphClkEn), .periphResetN(periphResetN),
    .periphReady(periphReady));
  pgr_periph_model P0 (.mclk(mclk), .clkEn(periphClkEn[0]),
    .resetN(periphResetN[0]), .state_q(st0));
  pgr_periph_model P1 (.mclk(mclk), .clkEn(periphClkEn[1]),
    .resetN(periphResetN[1]), .state_q(st1));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task tk(input integer n);
    begin
      repeat (n) @(posedge mclk);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 chk(regRdata, e);
    end
  endtask
  // early access faults, disabled slot 2 too
  task t_enable;
    begin
      wr(8'h00, 32'h3);
      periphAccess <= 4'h5;
      tk(1);
      chk({28'h0, busFault}, 32'h5);
      periphAccess <= 4'h0;
      tk(8);
      chk({28'h0, periphReady}, 32'h3);
      @(posedge mclk);
      periphAccess <= 4'h1;
      @(posedge mclk);
      periphAccess <= 4'h0;
      #1;
      chk({28'h0, busFault}, 32'h0);
      rd(8'h0C, 32'h3);
      $display("enable done");
    end
  endtask
  task t_srst;
    begin
      wr(8'h08, 32'h1);
      tk(3);
      chk({28'h0, periphResetN}, 32'hE);
      chk({28'h0, periphReady}, 32'h2);
      chk({24'h0, st0}, 32'h0);
      tk(12);
      chk({28'h0, periphReady}, 32'h3);
      $display("soft reset done");
    end
  endtask
  task t_sleep;
    begin
      wr(8'h04, 32'h2);
      wr(8'h10, 32'h1);
      @(posedge mclk);
      cpuSleeping <= 1'b1;
      tk(1);
      held = st0;
      chk({28'h0, periphClkEn}, 32'h2);
      tk(4);
      chk({24'h0, st0}, {24'h0, held});
      @(posedge mclk);
      cpuSleeping <= 1'b0;
      tk(1);
      chk({24'h0, st0}, {24'h0, held + 8'h01});
      wr(8'h10, 32'h0);
      @(posedge mclk);
      cpuSleeping <= 1'b1;
      tk(1);
      chk({28'h0, periphClkEn}, 32'h3);
      rd(8'h04, 32'h2);
      cpuSleeping <= 1'b0;
      $display("sleep done");
    end
  endtask
  // writes while frozen must be lost
  task t_freeze;
    begin
      @(posedge mclk);
      ce <= 1'b0;
      wr(8'h00, 32'h0);
      @(posedge mclk);
      ce <= 1'b1;
      rd(8'h00, 32'h3);
      chk({28'h0, periphReady}, 32'h3);
      $display("freeze done");
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // hang guard well beyond the fewer than a hundred cycles used
  initial begin
    #20000;
    failures = failures + 1;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    tk(3);
    rd(8'h00, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h20, 32'h0);
    t_enable;
    t_srst;
    t_sleep;
    t_freeze;
    report_and_stop;
  end
endmodule
bind pgr_ctrl pgr_ctrl_props #(.NPERIPH(NPERIPH)) props (.mclk(mclk), .reset_n(reset_n),
  .regRd(regRd), .regRdata(regRdata), .cpuSleeping(cpuSleeping),
  .periphAccess(periphAccess), .busFault(busFault), .periphClkEn(periphClkEn),
  .periphResetN(periphResetN), .periphReady(periphReady));

// >>> verification/pgr_ctrl_props.sv
`timescale 1ns/1ps
module pgr_ctrl_props #(
  parameter NPERIPH = 32
) (
  input wire mclk,
  input wire reset_n,
  input wire regRd,
  input wire [31:0] regRdata,
  input wire cpuSleeping,
  input wire [NPERIPH-1:0] periphAccess,
  input wire [NPERIPH-1:0] busFault,
  input wire [NPERIPH-1:0] periphClkEn,
  input wire [NPERIPH-1:0] periphResetN,
  input wire [NPERIPH-1:0] periphReady
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // slot 0 watched closely, slot 1 as bystander
  rst_hides_ready_a: assert property (
    !periphResetN[0] |=> !periphReady[0]) else $error("ready in reset");
  srst_pulse_len_a: assert property (
    $fell(periphResetN[0]) |-> !periphResetN[0] [*4] ##1 periphResetN[0])
    else $error("reset pulse length");
  ready_settle_a: assert property (
    $rose(periphReady[0]) |-> $past(periphResetN[0], 4)) else $error("early ready");
  fault_early_a: assert property (
    periphAccess[0] && !periphReady[0] |=> busFault[0]) else $error("no fault");
  no_fault_ready_a: assert property (
    periphAccess[0] && periphReady[0] |=> !busFault[0]) else $error("bad fault");
  awake_clocked_a: assert property (
    periphReady[0] && !cpuSleeping |-> periphClkEn[0]) else $error("clock off");
  rdata_idle_a: assert property (
    !$past(regRd) |-> regRdata == 32'h0) else $error("stray read data");
  srst_isolated_a: assert property (
    $fell(periphResetN[0]) |-> periphResetN[1]) else $error("reset spread");
  cover property ($rose(periphReady[0]));
  cover property ($fell(periphResetN[0]));
  cover property (busFault[0]);
endmodule

// >>> verification/pgr_periph_model.sv
`timescale 1ns/1ps
// stand-in peripheral: a free counter is its whole state
module pgr_periph_model (
  input wire mclk,
  input wire clkEn,
  input wire resetN,
  output reg [7:0] state_q
);
  always @(posedge mclk) begin
    if (!resetN) begin
      state_q <= 8'h00;
    end else if (clkEn) begin
      state_q <= state_q + 8'h01;
    end
  end
endmodule
